// >>> logic/aps_pkg.sv
// Purpose: Shared constants and carrier types of the antenna program
//          sequencer.
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes:   Panel selectors and unit reports travel in one packed struct.
package aps_pkg;

  // Clock and debounce timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEB_TIME_NS   = 5000;
  localparam int DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // Stepper geometry
  localparam int        CHAN_COUNT = 10;
  localparam int        BEAR_COUNT = 8;
  localparam logic [3:0] CHAN_LAST = 4'h9;
  localparam logic [2:0] BEAR_LAST = 3'h7;
  localparam logic [2:0] BEAR_SOUTH = 3'h4;
  localparam int        CHAN10_BIT = 9;
  localparam int        CHAN9_BIT  = 8;

  // Register map (byte addresses)
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam int          CTRL_OVERRIDE_BIT = 0;
  localparam int          CTRL_CHANGE_BIT   = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Status field positions
  localparam int ST_CHAN_LSB  = 0;
  localparam int ST_BEAR_LSB  = 4;
  localparam int ST_OMNI      = 7;
  localparam int ST_NARROW    = 8;
  localparam int ST_BAND_HIGH = 9;
  localparam int ST_GO        = 10;
  localparam int ST_STEER     = 11;
  localparam int ST_TUNE      = 12;
  localparam int ST_ENABLED   = 13;

  typedef enum logic [0:0] {
    GO_IDLE = 1'b0,
    GO_RUN  = 1'b1
  } aps_go_e;

  typedef struct packed {
    logic [9:0] chan;
    logic [7:0] bear;
    logic       wide;
    logic       narrow;
    logic [1:0] omni;
    logic       low_band;
    logic       high_band;
    logic       start_pushbutton;
    logic       low_reflector_done;
    logic       high_reflector_done;
    logic       low_tune_done;
    logic       high_tune_done;
  } aps_panel_s;

  typedef struct packed {
    logic [9:0] low_chan_lamp;
    logic [9:0] high_chan_lamp;
    logic [7:0] bear_lamp;
    logic       low_band_lamp;
    logic       high_band_lamp;
    logic       wide_lamp;
    logic       narrow_lamp;
    logic       omni_lamp;
    logic       steer_lamp;
    logic       tune_lamp;
    logic       enabled_lamp;
    logic       channel_step_drive;
    logic       bearing_step_drive;
    logic       mode_toggle_drive;
    logic       beam_toggle_drive;
    logic       go_latch;
    logic       matching_power_enable;
    logic       reflector_power_enable;
    logic       go_reflector;
    logic       go_tune;
    logic       low_step_cmd;
    logic       high_step_cmd;
    logic       low_omni_cmd;
    logic       high_omni_cmd;
  } aps_out_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } aps_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } aps_axil_rsp_s;

endpackage

// >>> logic/aps_sequencer.sv
// Purpose: Antenna program sequencer: channel and bearing steppers,
//          beamwidth, mode and band memories, start/go latch.
// Assumes: Panel inputs synchronous to aclk; AXI4-Lite register access.
// Notes:   Electromechanical timing is replaced by one step per cycle.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module aps_sequencer
  import aps_pkg::*;
#(
  parameter int DEB_COUNT = DEB_CYCLES
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Register bus
  input  wire aps_axil_req_s axil_req,
  output var  aps_axil_rsp_s axil_rsp,
  // Panel keys and unit reports
  input  wire aps_panel_s    panel,
  // Lamps, drives and unit commands
  output var  aps_out_s      out
);

  typedef struct packed {
    aps_panel_s    sync1;
    aps_panel_s    sync2;
    aps_panel_s    cand;
    aps_panel_s    db;
    logic [15:0]   deb_cnt;
    logic [7:0]    ctrl;
    logic [3:0]    chan_pos;
    logic [2:0]    bear_pos;
    logic          mode_omni;
    logic          beam_narrow;
    logic          band_high;
    aps_go_e       go_st;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    aps_axil_rsp_s rsp;
    aps_out_s      o;
  } aps_state_s;

  aps_state_s s;
  aps_state_s next_s;

  function automatic logic one_hot(input logic [9:0] v);
    return (v != 10'h000) && ((v & (v - 10'h001)) == 10'h000);
  endfunction

  function automatic logic [3:0] hot_index(input logic [9:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = CHAN_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [9:0] decode(input logic [3:0] p);
    return 10'h001 << p;
  endfunction

  logic       en;
  logic       live;
  logic       chan_any;
  logic       bear_any;
  logic       omni_any;
  logic       ch_ok;
  logic       be_ok;
  logic       steer_ok;
  logic       tune_ok;
  logic       settled;
  logic [3:0] ch_tgt;
  logic [2:0] be_tgt;
  logic [3:0] be_idx;

  always_comb begin
    next_s = s;

    // Two flops, then the whole key vector must hold still for the
    // debounce time; one counter serves all keys to save area
    next_s.sync1 = panel;
    next_s.sync2 = s.sync1;
    if (s.sync2 != s.cand) begin
      next_s.cand    = s.sync2;
      next_s.deb_cnt = 16'h0000;
    end else if (s.deb_cnt >= 16'(DEB_COUNT - 1)) begin
      next_s.db = s.cand;
    end else begin
      next_s.deb_cnt = s.deb_cnt + 16'h0001;
    end

    en = !s.ctrl[CTRL_OVERRIDE_BIT] && s.ctrl[CTRL_CHANGE_BIT];
    live = en && (s.go_st == GO_IDLE);
    chan_any = |s.db.chan;
    bear_any = |s.db.bear;
    omni_any = |s.db.omni;

    // Channel stepper
    ch_tgt = hot_index(s.db.chan);
    ch_ok = live && one_hot(s.db.chan) && !s.db.wide
            && !s.db.narrow && !bear_any;
    next_s.o.channel_step_drive = ch_ok && (s.chan_pos != ch_tgt);
    if (next_s.o.channel_step_drive) begin
      next_s.chan_pos = (s.chan_pos == CHAN_LAST) ? 4'h0
                        : s.chan_pos + 4'h1;
    end

    // Bearing stepper, position index 4 is south
    be_idx = hot_index({2'b00, s.db.bear});
    be_tgt = be_idx[2:0];
    be_ok = live && one_hot({2'b00, s.db.bear}) && !chan_any;
    next_s.o.bearing_step_drive = be_ok && (s.bear_pos != be_tgt);
    if (next_s.o.bearing_step_drive) begin
      next_s.bear_pos = (s.bear_pos == BEAR_LAST) ? 3'h0
                        : s.bear_pos + 3'h1;
    end

    // Band memory; channel keys lock out band keys
    if (live && !chan_any && !s.db.wide && !s.db.narrow) begin
      if (s.db.low_band && !s.db.high_band) begin
        next_s.band_high = 1'b0;
      end else if (s.db.high_band && !s.db.low_band) begin
        next_s.band_high = 1'b1;
      end
    end

    // Mode and beamwidth memories latch on the falling end of a
    // one-cycle drive pulse, so a held key cannot toggle twice
    next_s.o.mode_toggle_drive = 1'b0;
    next_s.o.beam_toggle_drive = 1'b0;
    if (s.o.mode_toggle_drive) begin
      next_s.mode_omni = !s.mode_omni;
    end else if (s.o.beam_toggle_drive) begin
      next_s.beam_narrow = !s.beam_narrow;
    end else if (live && !chan_any) begin
      if ((s.db.wide || s.db.narrow) && s.mode_omni) begin
        next_s.o.mode_toggle_drive = 1'b1;
      end else if (s.db.wide && s.beam_narrow && !s.db.narrow
                   && !s.db.high_band && !s.db.chan[CHAN10_BIT]) begin
        next_s.o.beam_toggle_drive = 1'b1;
      end else if (s.db.narrow && !s.beam_narrow && !s.db.wide
                   && !s.db.low_band && !s.db.chan[CHAN9_BIT]) begin
        next_s.o.beam_toggle_drive = 1'b1;
      end else if (omni_any && !s.mode_omni && !s.db.wide
                   && !s.db.narrow) begin
        next_s.o.mode_toggle_drive = 1'b1;
      end
    end

    // Start and go latch
    steer_ok = s.db.low_reflector_done && s.db.high_reflector_done;
    tune_ok  = s.db.low_tune_done && s.db.high_tune_done;
    // A key held with start must not move anything once go is set
    settled  = !s.o.channel_step_drive && !s.o.bearing_step_drive
               && !s.o.mode_toggle_drive && !s.o.beam_toggle_drive
               && !next_s.o.channel_step_drive
               && !next_s.o.bearing_step_drive
               && !next_s.o.mode_toggle_drive
               && !next_s.o.beam_toggle_drive;
    unique case (s.go_st)
      GO_IDLE: begin
        if (live && s.db.start_pushbutton && settled) begin
          next_s.go_st = GO_RUN;
        end
      end
      GO_RUN: begin
        if (steer_ok && tune_ok) begin
          next_s.go_st = GO_IDLE;
        end else begin
          next_s.go_st = GO_RUN;
        end
      end
    endcase

    // Lamps and unit commands
    next_s.o.low_chan_lamp  = next_s.band_high ? 10'h000
                              : decode(next_s.chan_pos);
    next_s.o.high_chan_lamp = next_s.band_high
                              ? decode(next_s.chan_pos) : 10'h000;
    next_s.o.low_band_lamp  = !next_s.band_high;
    next_s.o.high_band_lamp = next_s.band_high;
    next_s.o.bear_lamp = (!next_s.o.bearing_step_drive
                          && !next_s.mode_omni)
                         ? 8'(8'h01 << next_s.bear_pos) : 8'h00;
    next_s.o.wide_lamp   = !next_s.mode_omni && !next_s.beam_narrow;
    next_s.o.narrow_lamp = !next_s.mode_omni && next_s.beam_narrow;
    next_s.o.omni_lamp   = next_s.mode_omni;
    next_s.o.enabled_lamp = en;
    next_s.o.go_latch = (next_s.go_st == GO_RUN);
    next_s.o.steer_lamp = next_s.o.go_latch && !steer_ok;
    next_s.o.tune_lamp  = next_s.o.go_latch && !tune_ok;
    next_s.o.matching_power_enable  = next_s.o.go_latch;
    next_s.o.reflector_power_enable = next_s.o.go_latch;
    next_s.o.go_reflector = next_s.o.go_latch;
    next_s.o.go_tune      = next_s.o.go_latch;
    next_s.o.low_step_cmd  = next_s.o.go_latch && !next_s.band_high;
    next_s.o.high_step_cmd = next_s.o.go_latch && next_s.band_high;
    next_s.o.low_omni_cmd  = next_s.o.go_latch && next_s.band_high;
    next_s.o.high_omni_cmd = next_s.o.go_latch && !next_s.band_high;

    // AXI4-Lite write: address and data taken in either order
    if (s.rsp.awready && axil_req.awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.waddr  = axil_req.awaddr;
    end
    if (s.rsp.wready && axil_req.wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axil_req.wdata;
      next_s.wstrb = axil_req.wstrb;
    end
    if (s.rsp.bvalid && axil_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = RESP_OKAY;
      if (s.waddr == REG_CTRL) begin
        if (s.wstrb[0]) begin
          next_s.ctrl = s.wdata[7:0];
        end
      end else if (s.waddr != REG_STATUS) begin
        next_s.rsp.bresp = RESP_SLVERR;
      end
    end
    next_s.rsp.awready = !next_s.aw_got;
    next_s.rsp.wready  = !next_s.w_got;

    // AXI4-Lite read; status is read-only and ignores writes
    if (s.rsp.rvalid && axil_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (s.rsp.arready && axil_req.arvalid) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp  = RESP_OKAY;
      next_s.rsp.rdata  = 32'h0000_0000;
      if (axil_req.araddr == REG_CTRL) begin
        next_s.rsp.rdata[7:0] = s.ctrl;
      end else if (axil_req.araddr == REG_STATUS) begin
        next_s.rsp.rdata[ST_CHAN_LSB +: 4] = s.chan_pos;
        next_s.rsp.rdata[ST_BEAR_LSB +: 3] = s.bear_pos;
        next_s.rsp.rdata[ST_OMNI]      = s.mode_omni;
        next_s.rsp.rdata[ST_NARROW]    = s.beam_narrow;
        next_s.rsp.rdata[ST_BAND_HIGH] = s.band_high;
        next_s.rsp.rdata[ST_GO]        = s.o.go_latch;
        next_s.rsp.rdata[ST_STEER]     = steer_ok;
        next_s.rsp.rdata[ST_TUNE]      = tune_ok;
        next_s.rsp.rdata[ST_ENABLED]   = en;
      end else begin
        next_s.rsp.rresp = RESP_SLVERR;
      end
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  // All-zero reset means directional, wide, low band, first positions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign axil_rsp = s.rsp;
  assign out      = s.o;

endmodule // aps_sequencer

`default_nettype wire

// >>> tb/aps_sequencer_assertions.sv
// Purpose: Port-level assertions for the antenna program sequencer.
// Assumes: One aclk domain, synchronous active-low aresetn.
// Notes:   Watches design ports; bound into every instance.
`timescale 1ns/1ps
`default_nettype none

module aps_sequencer_chk
  import aps_pkg::*;
#(
  parameter int DEB_COUNT = DEB_CYCLES
) (
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Observed ports
  input wire aps_axil_req_s axil_req,
  input wire aps_axil_rsp_s axil_rsp,
  input wire aps_panel_s    panel,
  input wire aps_out_s      out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_go_powers: assert property (
    out.go_latch == (out.matching_power_enable & out.reflector_power_enable
                     & out.go_reflector & out.go_tune))
    else $error("go and unit power differ");
  a_band_route: assert property (
    {out.low_step_cmd, out.high_step_cmd, out.low_omni_cmd, out.high_omni_cmd}
    == {out.go_latch & out.low_band_lamp, out.go_latch & out.high_band_lamp,
        out.go_latch & out.high_band_lamp, out.go_latch & out.low_band_lamp})
    else $error("unit commands not routed by band");
  a_chan_row: assert property (
    (|out.high_chan_lamp) |-> out.high_band_lamp && out.low_chan_lamp == '0
    && $onehot(out.high_chan_lamp))
    else $error("channel lamp on wrong row");
  a_wide_lamp: assert property (
    out.wide_lamp |-> !out.omni_lamp && !out.narrow_lamp)
    else $error("wide lamp lit in omni or narrow");
  a_bear_lamp: assert property (
    (|out.bear_lamp) |-> $onehot(out.bear_lamp) && !out.omni_lamp
    && !out.bearing_step_drive)
    else $error("bearing lamp lit while moving or omni");
  a_drive_excl: assert property (
    out.bearing_step_drive |-> !out.channel_step_drive)
    else $error("both steppers driven");
  a_go_locks: assert property (
    out.go_latch |-> !(out.channel_step_drive | out.bearing_step_drive
                       | out.mode_toggle_drive | out.beam_toggle_drive))
    else $error("drive active while go");
  a_go_lamps: assert property (
    $rose(out.go_latch) |-> out.steer_lamp && out.tune_lamp)
    else $error("go without progress lamps");
  a_go_clear: assert property (
    $fell(out.go_latch) |-> !out.steer_lamp && !out.tune_lamp)
    else $error("go cleared with work pending");
  a_pulse_once: assert property (
    out.mode_toggle_drive |=> !out.mode_toggle_drive[*2])
    else $error("mode toggle pulse too long");

  c_go: cover property ($rose(out.go_latch));
  c_chan: cover property (out.channel_step_drive);
  c_beam: cover property (out.beam_toggle_drive);
  c_read: cover property (axil_rsp.rvalid && axil_req.rready);
  c_start: cover property (panel.start_pushbutton && out.enabled_lamp);
endmodule // aps_sequencer_chk

bind aps_sequencer aps_sequencer_chk #(.DEB_COUNT(DEB_COUNT)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
  .axil_rsp(axil_rsp), .panel(panel), .out(out));
`default_nettype wire

// >>> tb/aps_unit_model.sv
// Purpose: Reflector and matching units of both antennas.
// Assumes: Units run only while go reflector is high.
// Notes:   Idle antenna answers at once; active one is slow on purpose.
`timescale 1ns/1ps
`default_nettype none

module aps_unit_model
  import aps_pkg::*;
#(
  parameter int STEER_CYC = 20,
  parameter int TUNE_CYC  = 60
) (
  // Clock and reset
  input  wire logic     aclk,
  input  wire logic     aresetn,
  // Commands and reports
  input  wire aps_out_s out,
  output var  logic     low_refl_done,
  output var  logic     high_refl_done,
  output var  logic     low_tune_done,
  output var  logic     high_tune_done
);
  int cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !out.go_reflector) begin
      cnt <= 0;
      {low_refl_done, high_refl_done, low_tune_done, high_tune_done} <= '0;
    end else begin
      cnt <= cnt + 1;
      // Omni return costs nothing, so the idle side reports at once
      low_refl_done  <= out.low_omni_cmd | (cnt >= STEER_CYC);
      high_refl_done <= out.high_omni_cmd | (cnt >= STEER_CYC);
      low_tune_done  <= out.low_omni_cmd | (cnt >= TUNE_CYC);
      high_tune_done <= out.high_omni_cmd | (cnt >= TUNE_CYC);
    end
  end
endmodule // aps_unit_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench of the antenna program sequencer.
// Assumes: DEB_COUNT of 2 keeps key debounce short.
// Notes:   Register reads are checked from a queue by a monitor.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import aps_pkg::*;
  localparam logic [31:0] SM = ~((32'h1 << ST_STEER) | (32'h1 << ST_TUNE));
  logic          aclk;
  logic          aresetn;
  aps_axil_req_s req;
  aps_axil_rsp_s rsp;
  aps_panel_s    keys;
  aps_panel_s    panel;
  aps_out_s      out;
  logic          lrd, hrd, ltd, htd;
  int            n_fail = 0, cmp_count = 0, cyc = 0;
  logic [31:0]   ccnt, bcnt, mcnt, wcnt;
  int            c;
  logic [31:0]   exp_q[$], msk_q[$];
  logic [1:0]    rsp_q[$], b_q[$];

  always_comb begin
    panel = keys;
    panel.low_reflector_done = lrd;
    panel.high_reflector_done = hrd;
    panel.low_tune_done = ltd;
    panel.high_tune_done = htd;
  end

  aps_sequencer #(.DEB_COUNT(2)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .axil_req(req), .axil_rsp(rsp), .panel(panel), .out(out));
  aps_unit_model u_units (.aclk(aclk), .aresetn(aresetn), .out(out),
    .low_refl_done(lrd), .high_refl_done(hrd), .low_tune_done(ltd),
    .high_tune_done(htd));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hang counts as a failure and still reaches the report
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  always @(posedge aclk) begin
    if (rsp.rvalid && req.rready) begin
      chk("rdata", rsp.rdata & msk_q.pop_front(), exp_q.pop_front());
      chk("rresp", rsp.rresp, rsp_q.pop_front());
    end
    if (rsp.bvalid && req.bready)
      chk("bresp", rsp.bresp, b_q.pop_front());
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    rsp_q.push_back(r);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge aclk);
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    b_q.push_back(r);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && rsp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rsp.bvalid);
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Holds the keys for n cycles, then counts drive pulses a while longer
  task automatic press(input aps_panel_s k, input int n);
    ccnt = 0;
    bcnt = 0;
    mcnt = 0;
    wcnt = 0;
    keys <= k;
    for (int i = 0; i < n + 12; i++) begin
      @(posedge aclk);
      if (i == n)
        keys <= '0;
      ccnt += 32'(out.channel_step_drive);
      bcnt += 32'(out.bearing_step_drive);
      mcnt += 32'(out.mode_toggle_drive);
      wcnt += 32'(out.beam_toggle_drive);
    end
  endtask

  function automatic logic [31:0] st(input int ch, bp, hi);
    st = 32'h0;
    st[ST_CHAN_LSB +: 4] = ch[3:0];
    st[ST_BEAR_LSB +: 3] = bp[2:0];
    st[ST_BAND_HIGH] = hi[0];
    st[ST_ENABLED] = 1'b1;
  endfunction

  initial begin
    aps_panel_s k;
    void'($urandom(88));
    req = '0;
    keys = '0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(REG_CTRL, 32'h0, '1, RESP_OKAY);
    wr(REG_STATUS, 32'hffff, RESP_OKAY);
    rd(REG_STATUS, 32'h0, SM, RESP_OKAY);
    rd(8'h08, 32'h0, '1, RESP_SLVERR);
    wr(8'h0c, 32'h3, RESP_SLVERR);
    k = '0;
    k.chan[3] = 1'b1;
    press(k, 30);
    chk("locked steps", ccnt, 0);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    press(k, 30);
    chk("override steps", ccnt, 0);
    chk("disabled lamp", out.enabled_lamp, 1'b0);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    rd(REG_CTRL, 32'h2, '1, RESP_OKAY);
    chk("enabled lamp", out.enabled_lamp, 1'b1);
    $display("test reset and enable done");
    c = 1 + int'($urandom % 9);
    k = '0;
    k.chan[c] = 1'b1;
    k.omni = 2'b11;
    k.high_band = 1'b1;
    press(k, 30);
    chk("channel steps", ccnt, c);
    chk("low lamp", out.low_chan_lamp, 10'h1 << c);
    chk("omni ignored", out.omni_lamp, 1'b0);
    press(k, 30);
    chk("no step", ccnt, 0);
    k = '0;
    k.chan[0] = 1'b1;
    k.bear[1] = 1'b1;
    press(k, 30);
    chk("blocked steps", ccnt + bcnt, 0);
    rd(REG_STATUS, st(c, 0, 0), SM, RESP_OKAY);
    $display("test channel done");
    k = '0;
    k.bear[4] = 1'b1;
    press(k, 30);
    chk("bearing steps", bcnt, 4);
    chk("south lamp", out.bear_lamp, 8'h10);
    k = '0;
    k.omni[1] = 1'b1;
    press(k, 30);
    chk("omni toggles", mcnt, 1);
    chk("omni lamps", {out.omni_lamp, out.wide_lamp, out.bear_lamp}, 10'h200);
    k.omni = 2'b01;
    press(k, 30);
    chk("omni again", mcnt, 0);
    k = '0;
    k.narrow = 1'b1;
    press(k, 30);
    chk("narrow toggles", {mcnt[3:0], wcnt[3:0]}, 8'h11);
    chk("narrow lamps", {out.narrow_lamp, out.omni_lamp}, 2'b10);
    k.wide = 1'b1;
    press(k, 30);
    chk("wide refused", wcnt, 0);
    k.narrow = 1'b0;
    press(k, 30);
    chk("wide toggles", wcnt, 1);
    chk("wide lamp", out.wide_lamp, 1'b1);
    press(k, 30);
    chk("wide again", wcnt, 0);
    k = '0;
    k.high_band = 1'b1;
    press(k, 30);
    chk("high row", {out.high_chan_lamp, out.low_chan_lamp}, 20'h400 << c);
    rd(REG_STATUS, st(c, 4, 1), SM, RESP_OKAY);
    $display("test beam and band done");
    keys.start_pushbutton <= 1'b1;
    do @(posedge aclk); while (!out.go_latch);
    chk("go lamps", {out.steer_lamp, out.tune_lamp}, 2'b11);
    chk("routes", {out.high_step_cmd, out.low_omni_cmd, out.low_step_cmd}, 3'b110);
    k = '0;
    k.chan[0] = 1'b1;
    press(k, 10);
    chk("go locks keys", ccnt, 0);
    while (out.steer_lamp) @(posedge aclk);
    chk("steer first", {out.go_latch, out.tune_lamp}, 2'b11);
    while (out.go_latch) @(posedge aclk);
    chk("tune done", out.tune_lamp, 1'b0);
    press(k, 30);
    chk("keys back", ccnt, 10 - c);
    rd(REG_STATUS, st(0, 4, 1), SM, RESP_OKAY);
    $display("test start done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
